// >>> dts_asserts.sv
/*
 * Checker for the command pins that join the controller and memory ends.
 * Assumes it stands beside the interface instance and shares its clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dts_asserts (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 cke,
    input  wire dts_pkg::dts_cmd_type cmd,
    input  wire logic [2:0]           ba,
    input  wire logic [13:0]          a,
    input  wire logic                 odt
);
    logic       cke_p_q;
    logic       sr_q;
    logic [7:0] exit_cnt_q;
    logic       col;

    default clocking dck @(posedge clk);
    endclocking
    default disable iff (rst);

    assign col = (cmd == dts_pkg::CMD_RD) || (cmd == dts_pkg::CMD_WR);

    // Cycles since clock enable rose; it saturates so that an old exit
    // never wraps round and looks fresh again.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cke_p_q    <= 1'b1;
            sr_q       <= 1'b0;
            exit_cnt_q <= 8'hff;
        end else begin
            cke_p_q <= cke;
            if (!cke && cke_p_q) begin
                sr_q <= (cmd == dts_pkg::CMD_REF);
            end
            if (cke && !cke_p_q) begin
                exit_cnt_q <= 8'h01;
            end else if (exit_cnt_q != 8'hff) begin
                exit_cnt_q <= exit_cnt_q + 8'h01;
            end
        end
    end

    property p_act;
        cmd == dts_pkg::CMD_ACT |=> cmd != dts_pkg::CMD_ACT;
    endproperty
    a_act: assert property (p_act) else $error("activates too close");
    property p_col;
        col |=> !col;
    endproperty
    a_col: assert property (p_col) else $error("column commands too close");
    property p_wtr;
        cmd == dts_pkg::CMD_WR |=> (cmd != dts_pkg::CMD_RD) [*4];
    endproperty
    a_wtr: assert property (p_wtr) else $error("read too soon after write");
    property p_dal;
        cmd == dts_pkg::CMD_WR && a[10] |=> (cmd != dts_pkg::CMD_ACT) [*6];
    endproperty
    a_dal: assert property (p_dal) else $error("activate too soon");
    property p_cke_lo;
        $fell(cke) |=> !cke [*2];
    endproperty
    a_cke_lo: assert property (p_cke_lo) else $error("short low enable");
    property p_cke_hi;
        $rose(cke) |=> cke [*2];
    endproperty
    a_cke_hi: assert property (p_cke_hi) else $error("short high enable");
    property p_mrd;
        cmd == dts_pkg::CMD_MRS |=> cmd == dts_pkg::CMD_NOP;
    endproperty
    a_mrd: assert property (p_mrd) else $error("command after mode set");
    property p_xp;
        cmd != dts_pkg::CMD_NOP |-> exit_cnt_q >= 8'h02;
    endproperty
    a_xp: assert property (p_xp) else $error("command too soon after exit");
    property p_xsrd;
        sr_q && cmd == dts_pkg::CMD_RD |-> exit_cnt_q >= 8'hc8;
    endproperty
    a_xsrd: assert property (p_xsrd) else $error("read too soon after wake");
    property p_anpd;
        $fell(cke) |-> odt == $past(odt) && odt == $past(odt, 2);
    endproperty
    a_anpd: assert property (p_anpd) else $error("odt moved before sleep");
    property p_axpd;
        $changed(odt) |-> exit_cnt_q >= 8'h08;
    endproperty
    a_axpd: assert property (p_axpd) else $error("odt moved after exit");

    c_pd_odt: cover property (!cke && $changed(odt));
    c_sr_rd: cover property (sr_q && cmd == dts_pkg::CMD_RD);
    c_dal: cover property (cmd == dts_pkg::CMD_WR && a[10]);
    c_emr: cover property (cmd == dts_pkg::CMD_MRS && ba == dts_pkg::BA_EMR);
endmodule
`default_nettype wire

// >>> dts_ctrl.sv
/*
 * Controller end: takes one user operation at a time and issues it on
 * the command pins only once every spacing window allows it.
 * Assumes a free-running clock and a user that holds a request until ack.
 */
`timescale 1ns/1ps
`default_nettype none
module dts_ctrl #(
    parameter bit X16      = 1'b0,
    parameter bit GRADE800 = 1'b0
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                req_valid,
    input  wire dts_pkg::dts_op_type req_op,
    input  wire logic [2:0]          req_ba,
    input  wire logic [13:0]         req_a,
    input  wire logic                odt_req,
    output logic                     req_ack_q,
    output logic                     pd_q,
    output logic                     sr_q,
    dts_ddr_if.ctrl                  pins
);
    localparam int AP = dts_pkg::A_AP_BIT;
    localparam int WEND = dts_pkg::WL_CYC + dts_pkg::BL / 2;
    localparam int RTP_OR_BL = (dts_pkg::RTP_CYC > dts_pkg::BL / 2)
                               ? dts_pkg::RTP_CYC : dts_pkg::BL / 2;
    localparam int XARDS = (GRADE800 ? dts_pkg::XARDS_800
                           : dts_pkg::XARDS_667) - dts_pkg::AL_CYC;

    dts_pkg::dts_state_type state_q;
    logic [7:0] act_q, col_q, rd_q, pre_q, any_q, nrd_q, cke_cnt_q, odt_lk_q;
    logic [7:0] act_ld, col_ld, rd_ld, pre_ld, any_ld, nrd_ld, odt_lk_ld;
    logic [7:0] odt_age_q;
    logic [7:0] open_q;
    logic       slow_q;
    logic       active_pd_q;
    logic       ok;
    logic       issue;

    // A load of n lets the next gated command out n+1 cycles later; a
    // window already longer is never shortened by a later command.
    function automatic logic [7:0] nxt(input logic [7:0] cur,
                                       input logic [7:0] ld);
        logic [7:0] dec;
        dec = (cur == 8'h00) ? 8'h00 : cur - 8'h01;
        return (ld > dec) ? ld : dec;
    endfunction

    function automatic logic [7:0] win(input int cyc);
        return 8'(cyc - 1);
    endfunction

    always_comb begin
        ok = 1'b0;
        if (state_q == dts_pkg::ST_IDLE) begin
            unique case (req_op)
                dts_pkg::OP_ACT: ok = act_q == 8'h00 && nrd_q == 8'h00
                                      && any_q == 8'h00;
                dts_pkg::OP_RD:  ok = col_q == 8'h00 && rd_q == 8'h00
                                      && any_q == 8'h00;
                dts_pkg::OP_WR:  ok = col_q == 8'h00 && nrd_q == 8'h00
                                      && any_q == 8'h00;
                dts_pkg::OP_PRE: ok = pre_q == 8'h00 && nrd_q == 8'h00
                                      && any_q == 8'h00;
                dts_pkg::OP_MRS, dts_pkg::OP_REF:
                    ok = act_q == 8'h00 && nrd_q == 8'h00
                         && any_q == 8'h00;
                dts_pkg::OP_PDE, dts_pkg::OP_SRE:
                    ok = cke_cnt_q == 8'h00 && nrd_q == 8'h00
                         && any_q == 8'h00 && odt_lk_q == 8'h00
                         && odt_age_q >= 8'(dts_pkg::ANPD_CYC)
                         && odt_req == pins.odt;
                default: ok = 1'b0;
            endcase
        end else begin
            ok = req_op == dts_pkg::OP_EXIT && cke_cnt_q == 8'h00;
        end
    end

    assign issue = req_valid && ok && !req_ack_q;

    always_comb begin
        act_ld    = 8'h00;
        col_ld    = 8'h00;
        rd_ld     = 8'h00;
        pre_ld    = 8'h00;
        any_ld    = 8'h00;
        nrd_ld    = 8'h00;
        odt_lk_ld = 8'h00;
        if (issue) begin
            unique case (req_op)
                dts_pkg::OP_ACT:
                    act_ld = win(X16 ? dts_pkg::RRD_X16_CYC
                                 : dts_pkg::RRD_X8_CYC);
                dts_pkg::OP_RD: begin
                    col_ld = win(dts_pkg::CCD_CYC);
                    pre_ld = win(dts_pkg::AL_CYC + RTP_OR_BL);
                    if (req_a[AP]) begin
                        act_ld = win(dts_pkg::AL_CYC + RTP_OR_BL
                                     + dts_pkg::RP_CYC);
                    end
                end
                dts_pkg::OP_WR: begin
                    col_ld = win(dts_pkg::CCD_CYC);
                    rd_ld  = win(WEND + dts_pkg::WTR_CYC);
                    pre_ld = win(WEND + dts_pkg::WR_CYC);
                    if (req_a[AP]) begin
                        act_ld = win(WEND + dts_pkg::WR_CYC
                                     + dts_pkg::RP_CYC);
                    end
                end
                dts_pkg::OP_PRE: act_ld = win(dts_pkg::RP_CYC);
                dts_pkg::OP_MRS: any_ld = win(dts_pkg::MRD_CYC);
                dts_pkg::OP_REF: any_ld = win(dts_pkg::RFC_CYC);
                dts_pkg::OP_EXIT: begin
                    odt_lk_ld = win(dts_pkg::AXPD_CYC);
                    if (state_q == dts_pkg::ST_SR) begin
                        nrd_ld = win(dts_pkg::XSNR_CYC);
                        rd_ld  = win(dts_pkg::XSRD_CYC);
                    end else if (!active_pd_q) begin
                        any_ld = win(dts_pkg::XP_CYC);
                    end else if (slow_q) begin
                        rd_ld = win(XARDS);
                    end else begin
                        rd_ld = win(dts_pkg::XARD_CYC);
                    end
                end
                default: act_ld = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_q    <= 8'h00;
            col_q    <= 8'h00;
            rd_q     <= 8'h00;
            pre_q    <= 8'h00;
            any_q    <= 8'h00;
            nrd_q    <= 8'h00;
            odt_lk_q <= 8'h00;
        end else begin
            act_q    <= nxt(act_q, act_ld);
            col_q    <= nxt(col_q, col_ld);
            rd_q     <= nxt(rd_q, rd_ld);
            pre_q    <= nxt(pre_q, pre_ld);
            any_q    <= nxt(any_q, any_ld);
            nrd_q    <= nxt(nrd_q, nrd_ld);
            odt_lk_q <= nxt(odt_lk_q, odt_lk_ld);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= dts_pkg::ST_IDLE;
            pins.cke    <= 1'b1;
            cke_cnt_q   <= 8'h00;
            active_pd_q <= 1'b0;
        end else if (issue && (req_op == dts_pkg::OP_PDE
                               || req_op == dts_pkg::OP_SRE)) begin
            // The clock never stops here, so the hold after a low CKE
            // edge is always met.
            state_q     <= (req_op == dts_pkg::OP_SRE) ? dts_pkg::ST_SR
                           : dts_pkg::ST_PD;
            pins.cke    <= 1'b0;
            cke_cnt_q   <= win(dts_pkg::CKE_CYC);
            active_pd_q <= |open_q;
        end else if (issue && req_op == dts_pkg::OP_EXIT) begin
            state_q   <= dts_pkg::ST_IDLE;
            pins.cke  <= 1'b1;
            cke_cnt_q <= win(dts_pkg::CKE_CYC);
        end else begin
            cke_cnt_q <= nxt(cke_cnt_q, 8'h00);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            open_q <= 8'h00;
            slow_q <= 1'b0;
        end else if (issue) begin
            if (req_op == dts_pkg::OP_ACT) begin
                open_q[req_ba] <= 1'b1;
            end else if (req_op == dts_pkg::OP_PRE && req_a[AP]) begin
                open_q <= 8'h00;
            end else if ((req_op == dts_pkg::OP_PRE || req_a[AP])
                         && (req_op == dts_pkg::OP_PRE
                             || req_op == dts_pkg::OP_RD
                             || req_op == dts_pkg::OP_WR)) begin
                open_q[req_ba] <= 1'b0;
            end else if (req_op == dts_pkg::OP_MRS
                         && req_ba == dts_pkg::BA_MR) begin
                slow_q <= req_a[dts_pkg::MR_PDX_SLOW_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pins.cmd  <= dts_pkg::CMD_NOP;
            pins.ba   <= 3'h0;
            pins.a    <= 14'h0000;
            req_ack_q <= 1'b0;
        end else begin
            req_ack_q <= issue;
            pins.ba   <= req_ba;
            pins.a    <= req_a;
            pins.cmd  <= dts_pkg::CMD_NOP;
            if (issue) begin
                unique case (req_op)
                    dts_pkg::OP_ACT: pins.cmd <= dts_pkg::CMD_ACT;
                    dts_pkg::OP_RD:  pins.cmd <= dts_pkg::CMD_RD;
                    dts_pkg::OP_WR:  pins.cmd <= dts_pkg::CMD_WR;
                    dts_pkg::OP_PRE: pins.cmd <= dts_pkg::CMD_PRE;
                    dts_pkg::OP_MRS: pins.cmd <= dts_pkg::CMD_MRS;
                    dts_pkg::OP_REF, dts_pkg::OP_SRE:
                        pins.cmd <= dts_pkg::CMD_REF;
                    default: pins.cmd <= dts_pkg::CMD_NOP;
                endcase
            end
        end
    end

    // Termination follows the user, also in power-down, where the memory
    // answers on its short path. It is frozen in self-refresh, on the exit
    // edge and for the lock window after exit, when neither path is timed.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pins.odt  <= 1'b0;
            odt_age_q <= 8'h00;
        end else if ((state_q == dts_pkg::ST_PD && !issue
                      || state_q == dts_pkg::ST_IDLE && odt_lk_q == 8'h00)
                     && odt_req != pins.odt) begin
            pins.odt  <= odt_req;
            odt_age_q <= 8'h00;
        end else if (odt_age_q != 8'hff) begin
            odt_age_q <= odt_age_q + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_q <= 1'b0;
            sr_q <= 1'b0;
        end else begin
            pd_q <= issue && req_op == dts_pkg::OP_PDE
                    || pd_q && !(issue && req_op == dts_pkg::OP_EXIT);
            sr_q <= issue && req_op == dts_pkg::OP_SRE
                    || sr_q && !(issue && req_op == dts_pkg::OP_EXIT);
        end
    end
endmodule
`default_nettype wire

// >>> dts_ddr_if.sv
/*
 * Command pins between the controller end and the memory end.
 * Assumes both ends share clk; every signal is driven from a flip-flop.
 */
`timescale 1ns/1ps
`default_nettype none
interface dts_ddr_if;
    logic                cke;
    dts_pkg::dts_cmd_type cmd;
    logic [2:0]          ba;
    logic [13:0]         a;
    logic                odt;

    modport ctrl (output cke, output cmd, output ba, output a, output odt);
    modport mem  (input cke, input cmd, input ba, input a, input odt);
endinterface
`default_nettype wire

// >>> dts_mem.sv
/*
 * Memory end: termination timing, strobe mode, drive calibration state
 * and the power-down exit mode captured from mode register commands.
 * Assumes the controller keeps its spacing; no checking is done here.
 */
`timescale 1ns/1ps
`default_nettype none
module dts_mem (
    input  wire logic                      clk,
    input  wire logic                      rst,
    dts_ddr_if.mem                         pins,
    output logic                           term_on_q,
    output logic                           dqs_diff_q,
    output logic [dts_pkg::OCD_W-1:0]      ocd_q,
    output logic                           slow_pdx_q,
    output logic                           pd_q
);
    logic [1:0] odt_hist_q;
    logic       term_on_d;
    logic       emr_wr;
    logic       mr_wr;

    assign emr_wr = pins.cke && pins.cmd == dts_pkg::CMD_MRS
                    && pins.ba == dts_pkg::BA_EMR;
    assign mr_wr  = pins.cke && pins.cmd == dts_pkg::CMD_MRS
                    && pins.ba == dts_pkg::BA_MR;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            odt_hist_q <= 2'h0;
        end else begin
            odt_hist_q <= {odt_hist_q[0], pins.odt};
        end
    end

    // Awake, turn-on lands two cycles after the pin and turn-off three,
    // the half cycle rounded up to the next rising edge. In power-down
    // the path is short: one cycle on, two off, inside the loose bounds.
    always_comb begin
        if (pins.cke) begin
            term_on_d = odt_hist_q[0] | (odt_hist_q[1] & term_on_q);
        end else begin
            term_on_d = pins.odt | (odt_hist_q[0] & term_on_q);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            term_on_q <= 1'b0;
        end else begin
            term_on_q <= term_on_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dqs_diff_q <= 1'b1;
            ocd_q      <= '0;
        end else if (emr_wr) begin
            dqs_diff_q <= ~pins.a[dts_pkg::EMR_DQS_DIS_BIT];
            ocd_q      <= pins.a[dts_pkg::EMR_OCD_LSB +: dts_pkg::OCD_W];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slow_pdx_q <= 1'b0;
        end else if (mr_wr) begin
            slow_pdx_q <= pins.a[dts_pkg::MR_PDX_SLOW_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= ~pins.cke;
        end
    end
endmodule
`default_nettype wire

// >>> dts_pkg.sv
/*
 * Shared constants and types for the DDR2 command spacing pair: the
 * controller end and the memory end. Assumes a single 40 MHz clock that
 * both ends run on, and command fields sampled on its rising edge.
 */
`default_nettype none
package dts_pkg;
    localparam int CLK_PS = 25000;

    // A least time rounds up to whole cycles and never drops below floor_c.
    function automatic int least_cyc(input int ps, input int floor_c);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < floor_c) ? floor_c : c;
    endfunction

    localparam int T_RRD_X8_PS   = 7500;
    localparam int T_RRD_X16_PS  = 10000;
    localparam int T_WR_PS       = 15000;
    localparam int T_WTR_PS      = 7500;
    localparam int T_RTP_PS      = 7500;
    localparam int T_RFC_PS      = 130000;
    localparam int T_XSNR_ADD_PS = 10000;
    localparam int T_OIT_PS      = 12000;

    localparam int RRD_X8_CYC  = least_cyc(T_RRD_X8_PS, 2);
    localparam int RRD_X16_CYC = least_cyc(T_RRD_X16_PS, 2);
    localparam int WR_CYC      = least_cyc(T_WR_PS, 1);
    localparam int WTR_CYC     = least_cyc(T_WTR_PS, 1);
    localparam int RTP_CYC     = least_cyc(T_RTP_PS, 1);
    localparam int RFC_CYC     = least_cyc(T_RFC_PS, 1);
    localparam int XSNR_CYC    = least_cyc(T_RFC_PS + T_XSNR_ADD_PS, 1);
    // A longest time rounds down, but never below one cycle.
    localparam int OIT_CYC     = (T_OIT_PS / CLK_PS < 1) ? 1
                                 : T_OIT_PS / CLK_PS;

    localparam int CCD_CYC    = 2;
    localparam int CKE_CYC    = 3;
    localparam int XSRD_CYC   = 200;
    localparam int XP_CYC     = 2;
    localparam int XARD_CYC   = 2;
    localparam int XARDS_667  = 7;
    localparam int XARDS_800  = 8;
    localparam int MRD_CYC    = 2;
    localparam int RP_CYC     = 2;
    localparam int ANPD_CYC   = 3;
    localparam int AXPD_CYC   = 8;
    localparam int AOND_CYC   = 2;
    localparam int AOFD_CYC   = 3;
    localparam int AL_CYC     = 0;
    localparam int CL_CYC     = 3;
    localparam int BL         = 4;
    localparam int WL_CYC     = AL_CYC + CL_CYC - 1;

    localparam int A_AP_BIT        = 10;
    localparam int MR_PDX_SLOW_BIT = 12;
    localparam int EMR_DQS_DIS_BIT = 10;
    localparam int EMR_OCD_LSB     = 7;
    localparam int OCD_W           = 3;
    localparam logic [2:0] BA_MR   = 3'h0;
    localparam logic [2:0] BA_EMR  = 3'h1;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_ACT = 3'h1,
        CMD_RD  = 3'h2,
        CMD_WR  = 3'h3,
        CMD_PRE = 3'h4,
        CMD_MRS = 3'h5,
        CMD_REF = 3'h6
    } dts_cmd_type;

    typedef enum logic [3:0] {
        OP_ACT  = 4'h0,
        OP_RD   = 4'h1,
        OP_WR   = 4'h2,
        OP_PRE  = 4'h3,
        OP_MRS  = 4'h4,
        OP_REF  = 4'h5,
        OP_PDE  = 4'h6,
        OP_SRE  = 4'h7,
        OP_EXIT = 4'h8
    } dts_op_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PD   = 3'b010,
        ST_SR   = 3'b100
    } dts_state_type;
endpackage
`default_nettype wire

// >>> test_ddr2_command_spacing_timing.sv
/*
 * Self-checking bench: drives the controller end, which talks to the
 * memory end, and models command spacing and termination timing.
 * Assumes a 40 MHz clock and the hand-over latencies of both ends.
 */
`timescale 1ns/1ps
`default_nettype none
module test_ddr2_command_spacing_timing;
    logic                        clk = 1'b0;
    logic                        rst;
    logic                        req_valid;
    dts_pkg::dts_op_type         req_op;
    logic [2:0]                  req_ba;
    logic [13:0]                 req_a;
    logic                        odt_req;
    logic                        req_ack_q;
    logic                        ctrl_pd;
    logic                        ctrl_sr;
    logic                        term_on;
    logic                        dqs_diff;
    logic [dts_pkg::OCD_W-1:0]   ocd;
    logic                        slow_pdx;
    logic                        mem_pd;
    logic                        exp_term;
    logic                        odt_p;
    logic                        ev_v[$];
    int                          ev_t[$];
    int                          cyc = 0;
    int                          last_ack = 0;
    int                          miscompares = 0;
    int                          cmp_count = 0;
    int                          seed = 32'hd1bdb769;

    dts_ddr_if dts_ddr_if_i ();
    dts_ctrl #(.X16(1'b0), .GRADE800(1'b0)) dts_ctrl_i (
        .clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_ba(req_ba), .req_a(req_a), .odt_req(odt_req),
        .req_ack_q(req_ack_q), .pd_q(ctrl_pd), .sr_q(ctrl_sr),
        .pins(dts_ddr_if_i));
    dts_mem dts_mem_i (
        .clk(clk), .rst(rst), .pins(dts_ddr_if_i), .term_on_q(term_on),
        .dqs_diff_q(dqs_diff), .ocd_q(ocd), .slow_pdx_q(slow_pdx),
        .pd_q(mem_pd));
    dts_asserts dts_asserts_i (
        .clk(clk), .rst(rst), .cke(dts_ddr_if_i.cke),
        .cmd(dts_ddr_if_i.cmd), .ba(dts_ddr_if_i.ba),
        .a(dts_ddr_if_i.a), .odt(dts_ddr_if_i.odt));

    always #12.5 clk = ~clk;
    always @(posedge clk) cyc++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %0h wanted %0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("%0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        req_valid = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Issues one operation and, for a gap of zero or more, checks the edge count since the last ack.
    // Valid is left up: the caller changes the op in the ack cycle.
    task automatic step(input dts_pkg::dts_op_type op, input logic [2:0] b,
                        input logic [13:0] addr, input int gap);
        int n;
        n = 0;
        req_op = op;
        req_ba = b;
        req_a = addr;
        if (op inside {dts_pkg::OP_ACT, dts_pkg::OP_RD, dts_pkg::OP_WR}) begin
            req_a[9:0] = 10'($random(seed));
        end
        req_valid = 1'b1;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (req_ack_q !== 1'b1 && n < 400);
        if (n >= 400) begin
            miscompares++;
            complete_run();
        end
        if (gap >= 0) begin
            check(32'(cyc - last_ack), 32'(gap));
        end
        last_ack = cyc;
    endtask

    // Each odt edge schedules the termination level it should cause.
    always @(posedge clk) begin
        #2;
        if (rst) begin
            ev_t.delete();
            ev_v.delete();
            exp_term = 1'b0;
            odt_p = 1'b0;
        end else begin
            if (dts_ddr_if_i.odt !== odt_p) begin
                ev_t.push_back(cyc + (dts_ddr_if_i.odt ? 2 : 3)
                               - (dts_ddr_if_i.cke ? 0 : 1));
                ev_v.push_back(dts_ddr_if_i.odt);
            end
            odt_p = dts_ddr_if_i.odt;
            if (ev_t.size() > 0 && ev_t[0] == cyc) begin
                exp_term = ev_v.pop_front();
                ev_t.delete(0);
            end
            check(32'(term_on), 32'(exp_term));
        end
    end

    initial begin
        int k;
        int wl;
        int hb;
        int wr;
        int xs;
        int rp;
        rst = 1'b1;
        req_valid = 1'b0;
        req_op = dts_pkg::OP_ACT;
        req_ba = 3'h0;
        req_a = 14'h0000;
        odt_req = 1'b0;
        wl = dts_pkg::AL_CYC + dts_pkg::CL_CYC - 1;
        hb = dts_pkg::BL / 2;
        wr = (dts_pkg::T_WR_PS + 24999) / 25000;
        xs = (dts_pkg::T_RFC_PS + dts_pkg::T_XSNR_ADD_PS + 24999) / 25000;
        rp = dts_pkg::RP_CYC;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        check(32'(dqs_diff), 32'h1);
        check(32'(dts_ddr_if_i.cke), 32'h1);
        odt_req = 1'b1;
        idle(12);
        $display("reset test done");
        step(dts_pkg::OP_ACT, 3'h0, 14'h0000, -1);
        step(dts_pkg::OP_ACT, 3'h1, 14'h0000, 2);
        step(dts_pkg::OP_WR, 3'h0, 14'h0000, -1);
        step(dts_pkg::OP_WR, 3'h1, 14'h0000, dts_pkg::CCD_CYC);
        step(dts_pkg::OP_RD, 3'h0, 14'h0000, wl + hb + 1);
        step(dts_pkg::OP_RD, 3'h1, 14'h0000, dts_pkg::CCD_CYC);
        step(dts_pkg::OP_PRE, 3'h1, 14'h0000, hb);
        step(dts_pkg::OP_PRE, 3'h0, 14'h0000, -1);
        step(dts_pkg::OP_ACT, 3'h2, 14'h0000, -1);
        step(dts_pkg::OP_WR, 3'h2, 14'h0000, -1);
        step(dts_pkg::OP_PRE, 3'h2, 14'h0000, wl + hb + wr);
        step(dts_pkg::OP_ACT, 3'h3, 14'h0000, -1);
        step(dts_pkg::OP_WR, 3'h3, 14'h0400, -1);
        step(dts_pkg::OP_ACT, 3'h3, 14'h0000, wl + hb + wr + rp);
        step(dts_pkg::OP_RD, 3'h3, 14'h0400, -1);
        step(dts_pkg::OP_ACT, 3'h3, 14'h0000, hb + rp);
        step(dts_pkg::OP_PRE, 3'h0, 14'h0400, -1);
        $display("bank test done");
        step(dts_pkg::OP_MRS, dts_pkg::BA_MR, 14'h1000, -1);
        for (k = 0; k < 8; k++) begin
            step(dts_pkg::OP_MRS, dts_pkg::BA_EMR,
                 14'((k << dts_pkg::EMR_OCD_LSB) | ((k & 1) << 10)),
                 (k == 0) ? dts_pkg::MRD_CYC : -1);
            idle(1);
            check(32'(ocd), 32'(k));
            check(32'(dqs_diff), 32'((k & 1) ^ 1));
        end
        check(32'(slow_pdx), 32'h1);
        $display("mode test done");
        // Termination moves while asleep, so the short path is timed too.
        step(dts_pkg::OP_PDE, 3'h0, 14'h0000, -1);
        idle(4);
        check(32'(ctrl_pd), 32'h1);
        check(32'(mem_pd), 32'h1);
        odt_req = 1'b0;
        idle(6);
        odt_req = 1'b1;
        idle(6);
        step(dts_pkg::OP_EXIT, 3'h0, 14'h0000, -1);
        odt_req = 1'b0;
        step(dts_pkg::OP_ACT, 3'h0, 14'h0000, dts_pkg::XP_CYC);
        step(dts_pkg::OP_PDE, 3'h0, 14'h0000, -1);
        step(dts_pkg::OP_EXIT, 3'h0, 14'h0000, dts_pkg::CKE_CYC);
        step(dts_pkg::OP_RD, 3'h0, 14'h0000,
             dts_pkg::XARDS_667 - dts_pkg::AL_CYC);
        step(dts_pkg::OP_PRE, 3'h0, 14'h0400, -1);
        step(dts_pkg::OP_MRS, dts_pkg::BA_MR, 14'h0000, -1);
        idle(1);
        check(32'(slow_pdx), 32'h0);
        step(dts_pkg::OP_ACT, 3'h0, 14'h0000, -1);
        step(dts_pkg::OP_PDE, 3'h0, 14'h0000, -1);
        step(dts_pkg::OP_EXIT, 3'h0, 14'h0000, -1);
        step(dts_pkg::OP_RD, 3'h0, 14'h0000, dts_pkg::XARD_CYC);
        $display("power-down test done");
        step(dts_pkg::OP_PRE, 3'h0, 14'h0400, -1);
        step(dts_pkg::OP_SRE, 3'h0, 14'h0000, -1);
        check(32'(ctrl_sr), 32'h1);
        check(32'(ctrl_pd), 32'h0);
        step(dts_pkg::OP_EXIT, 3'h0, 14'h0000, dts_pkg::CKE_CYC);
        step(dts_pkg::OP_ACT, 3'h0, 14'h0000, xs);
        check(32'(ctrl_sr), 32'h0);
        check(32'(mem_pd), 32'h0);
        step(dts_pkg::OP_RD, 3'h0, 14'h0000, dts_pkg::XSRD_CYC - xs);
        idle(4);
        $display("self-refresh test done");
        complete_run();
    end
endmodule
`default_nettype wire
